// ---- ipb_block.sv ----
// Identify parameter block: 256 sixteen-bit words, loaded by software
// over AXI4-Lite and read back shaped, plus a sequential word port for
// the task-file data path. Assumes one clock and a well-behaved master.
`timescale 1ns/1ps
module ipb_block #(
    parameter int unsigned NUM_WORDS = ipb_pkg::NUM_WORDS
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [11:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [11:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_id_start,
    input wire logic i_id_next,
    output logic [15:0] o_id_data,
    output logic [7:0] o_id_index
);
    logic [15:0] mem_ff [NUM_WORDS];
    logic [31:0] cap_ff;
    logic adv_ok;
    logic pio3;

    // Extra modes that oblige the timing words to be valid
    assign pio3 = |mem_ff[ipb_pkg::W_ADVPIO][1:0];
    assign adv_ok = mem_ff[ipb_pkg::W_VALID][ipb_pkg::B_ADV_OK]
        | pio3 | (|mem_ff[ipb_pkg::W_MWDMA][7:1]);

    // Shapes a stored word into what the host sees
    function automatic logic [15:0] shape(input logic [7:0] idx,
                                          input logic [15:0] raw);
        logic [15:0] v;
        v = raw;
        if (idx == ipb_pkg::W_GENCFG) begin
            v = raw & ipb_pkg::M_GENCFG;
        end else if (idx == ipb_pkg::W_CAPAB) begin
            v = raw & ipb_pkg::M_CAPAB;
            v[ipb_pkg::B_IORDY] = raw[ipb_pkg::B_IORDY] | pio3;
        end else if (idx == ipb_pkg::W_VALID) begin
            v = raw & ipb_pkg::M_VALID;
            v[ipb_pkg::B_ADV_OK] = adv_ok;
        end else if (idx == ipb_pkg::W_CAP_LO) begin
            v = cap_ff[15:0];
        end else if (idx == ipb_pkg::W_CAP_HI) begin
            v = cap_ff[31:16];
        end else if (idx == ipb_pkg::W_MULTSET) begin
            v = raw & ipb_pkg::M_MULTSET;
            if (mem_ff[ipb_pkg::W_MULTMAX][7:0] == 8'h00) begin
                v = 16'h0000;
            end
        end else if (idx == ipb_pkg::W_LBA_LO
                     || idx == ipb_pkg::W_LBA_HI) begin
            v = mem_ff[ipb_pkg::W_CAPAB][ipb_pkg::B_LBA] ? raw : 16'h0000;
        end else if (idx == ipb_pkg::W_ADVPIO) begin
            v = raw & ipb_pkg::M_ADVPIO;
        end else if (idx == ipb_pkg::W_RSV2 || idx == ipb_pkg::W_RSV48
                     || idx == ipb_pkg::W_RSV50) begin
            v = 16'h0000;
        end else if (idx >= ipb_pkg::W_RSV_LO
                     && idx <= ipb_pkg::W_RSV_HI) begin
            v = 16'h0000;
        end else if (idx > ipb_pkg::W_VEND_HI) begin
            v = 16'h0000;
        end
        return v;
    endfunction : shape

    // Write channel state
    logic aw_held_ff;
    logic nxt_aw_held;
    logic w_held_ff;
    logic nxt_w_held;
    logic [11:0] waddr_ff;
    logic [11:0] nxt_waddr;
    logic [31:0] wdata_ff;
    logic [31:0] nxt_wdata;
    logic [3:0] wstrb_ff;
    logic [3:0] nxt_wstrb;
    logic bvalid_ff;
    logic nxt_bvalid;
    logic [1:0] bresp_ff;
    logic [1:0] nxt_bresp;
    logic awready_ff;
    logic nxt_awready;
    logic wready_ff;
    logic nxt_wready;
    logic do_write;
    logic ctrl_en_ff;
    logic nxt_ctrl_en;

    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_w_held = w_held_ff;
        nxt_waddr = waddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_ctrl_en = ctrl_en_ff;
        do_write = 1'b0;
        if (i_awvalid && awready_ff) begin
            nxt_aw_held = 1'b1;
            nxt_waddr = i_awaddr;
        end
        if (i_wvalid && wready_ff) begin
            nxt_w_held = 1'b1;
            nxt_wdata = i_wdata;
            nxt_wstrb = i_wstrb;
        end
        if (bvalid_ff && i_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (aw_held_ff && w_held_ff && !bvalid_ff) begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = ipb_pkg::RESP_OKAY;
            if (waddr_ff <= ipb_pkg::A_BLK_END) begin
                do_write = 1'b1;
            end else if (waddr_ff[11:2] == ipb_pkg::A_CTRL[11:2]) begin
                if (wstrb_ff[0]) begin
                    nxt_ctrl_en = wdata_ff[0];
                end
            end else if (waddr_ff[11:2] != ipb_pkg::A_STATUS[11:2]) begin
                nxt_bresp = ipb_pkg::RESP_SLVERR;
            end
        end
        nxt_awready = !nxt_aw_held && !nxt_bvalid;
        nxt_wready = !nxt_w_held && !nxt_bvalid;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            waddr_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= ipb_pkg::RESP_OKAY;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            ctrl_en_ff <= 1'b1;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            waddr_ff <= nxt_waddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            ctrl_en_ff <= nxt_ctrl_en;
        end
    end

    // Parameter words; byte lanes 0 and 1 only, upper lanes ignored
    logic [7:0] widx;
    assign widx = waddr_ff[9:2];

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                mem_ff[i] <= 16'h0000;
            end
            mem_ff[ipb_pkg::W_LONGCNT] <= ipb_pkg::RST_LONGCNT;
        end else if (do_write) begin
            if (wstrb_ff[0]) begin
                mem_ff[widx][7:0] <= wdata_ff[7:0];
            end
            if (wstrb_ff[1]) begin
                mem_ff[widx][15:8] <= wdata_ff[15:8];
            end
        end
    end

    // Capacity product, registered to keep the multiplier off the read path
    logic [31:0] nxt_cap;
    logic [47:0] prod;

    always_comb begin
        prod = 48'(mem_ff[ipb_pkg::W_CUR_CYL]
            * mem_ff[ipb_pkg::W_CUR_HEAD]
            * mem_ff[ipb_pkg::W_CUR_SECT]);
        nxt_cap = prod[31:0];
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cap_ff <= 32'h0000_0000;
        end else begin
            cap_ff <= nxt_cap;
        end
    end

    // Sequential port for the task-file data path
    logic [7:0] ptr_ff;
    logic [7:0] nxt_ptr;
    logic [15:0] id_data_ff;
    logic [15:0] nxt_id_data;
    logic [7:0] id_index_ff;

    always_comb begin
        nxt_ptr = ptr_ff;
        if (i_id_start) begin
            nxt_ptr = 8'h00;
        end else if (i_id_next && ctrl_en_ff) begin
            // Wraps after the last word, as a fresh pass would
            nxt_ptr = ptr_ff + 8'h01;
        end
        nxt_id_data = shape(nxt_ptr, mem_ff[nxt_ptr]);
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ptr_ff <= 8'h00;
            id_data_ff <= 16'h0000;
            id_index_ff <= 8'h00;
        end else begin
            ptr_ff <= nxt_ptr;
            id_data_ff <= nxt_id_data;
            id_index_ff <= nxt_ptr;
        end
    end

    // Read channel
    logic arready_ff;
    logic nxt_arready;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0] rresp_ff;
    logic [1:0] nxt_rresp;
    logic [7:0] ridx;
    assign ridx = i_araddr[9:2];

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rvalid_ff && i_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (i_arvalid && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = ipb_pkg::RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            if (i_araddr <= ipb_pkg::A_BLK_END) begin
                nxt_rdata[15:0] = shape(ridx, mem_ff[ridx]);
            end else if (i_araddr[11:2] == ipb_pkg::A_STATUS[11:2]) begin
                nxt_rdata[7:0] = ptr_ff;
                nxt_rdata[8] = adv_ok;
            end else if (i_araddr[11:2] == ipb_pkg::A_CTRL[11:2]) begin
                nxt_rdata[0] = ctrl_en_ff;
            end else begin
                nxt_rresp = ipb_pkg::RESP_SLVERR;
            end
        end
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= ipb_pkg::RESP_OKAY;
        end else begin
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign o_awready = awready_ff;
    assign o_wready = wready_ff;
    assign o_bvalid = bvalid_ff;
    assign o_bresp = bresp_ff;
    assign o_arready = arready_ff;
    assign o_rvalid = rvalid_ff;
    assign o_rdata = rdata_ff;
    assign o_rresp = rresp_ff;
    assign o_id_data = id_data_ff;
    assign o_id_index = id_index_ff;
endmodule : ipb_block

// ---- ipb_pkg.sv ----
// Constants for the identify parameter block: word map, field positions,
// reset values and the register bus map.
// Assumes a 32-bit AXI4-Lite master and 16-bit parameter words.
package ipb_pkg;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned NUM_WORDS = 256;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // Word indices; byte address on the bus is four times the index
    localparam logic [7:0] W_GENCFG = 8'h00;
    localparam logic [7:0] W_RSV2 = 8'h02;
    localparam logic [7:0] W_LONGCNT = 8'h16;
    localparam logic [7:0] W_MULTMAX = 8'h2F;
    localparam logic [7:0] W_RSV48 = 8'h30;
    localparam logic [7:0] W_CAPAB = 8'h31;
    localparam logic [7:0] W_RSV50 = 8'h32;
    localparam logic [7:0] W_VALID = 8'h35;
    localparam logic [7:0] W_CUR_CYL = 8'h36;
    localparam logic [7:0] W_CUR_HEAD = 8'h37;
    localparam logic [7:0] W_CUR_SECT = 8'h38;
    localparam logic [7:0] W_CAP_LO = 8'h39;
    localparam logic [7:0] W_CAP_HI = 8'h3A;
    localparam logic [7:0] W_MULTSET = 8'h3B;
    localparam logic [7:0] W_LBA_LO = 8'h3C;
    localparam logic [7:0] W_LBA_HI = 8'h3D;
    localparam logic [7:0] W_SWDMA = 8'h3E;
    localparam logic [7:0] W_MWDMA = 8'h3F;
    localparam logic [7:0] W_ADVPIO = 8'h40;
    localparam logic [7:0] W_RSV_LO = 8'h45;
    localparam logic [7:0] W_RSV_HI = 8'h7F;
    localparam logic [7:0] W_VEND_HI = 8'h9F;

    // Read masks of the partly reserved words
    localparam logic [15:0] M_GENCFG = 16'h7FFF;
    localparam logic [15:0] M_CAPAB = 16'h2FFF;
    localparam logic [15:0] M_VALID = 16'h0001;
    localparam logic [15:0] M_MULTSET = 16'h01FF;
    localparam logic [15:0] M_ADVPIO = 16'h0003;
    localparam logic [15:0] M_ALL = 16'hFFFF;

    // Field positions
    localparam int unsigned B_ADV_OK = 1;
    localparam int unsigned B_IORDY = 11;
    localparam int unsigned B_LBA = 9;

    localparam logic [15:0] RST_LONGCNT = 16'h0004;

    // Block state registers beyond the parameter words
    localparam logic [11:0] A_STATUS = 12'h400;
    localparam logic [11:0] A_CTRL = 12'h404;
    localparam logic [11:0] A_BLK_END = 12'h3FF;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : ipb_pkg

// ---- ipb_block_monitor.sv ----
// Port checker for the identify parameter block.
// Sees only the top ports; bound onto every ipb_block instance.
`timescale 1ns/1ps
module ipb_block_monitor #(
    parameter int unsigned NUM_WORDS = ipb_pkg::NUM_WORDS
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic i_id_start,
    input wire logic [15:0] o_id_data,
    input wire logic [7:0] o_id_index
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read address taken but no answer");
    a_rdata_stands: assert property (o_rvalid && !i_rready
        |=> o_rvalid && $stable(o_rdata)) else $error("read data moved");
    a_rdata_upper: assert property (
        o_rvalid |-> o_rdata[31:16] == 16'h0000) else $error("upper half set");
    a_bresp_stands: assert property (o_bvalid && !i_bready
        |=> o_bvalid && $stable(o_bresp)) else $error("write answer moved");
    a_start_index: assert property (i_id_start |=> o_id_index == 8'h00)
        else $error("start did not restart at word zero");
    a_word0_top: assert property (
        o_id_index == 8'h00 |-> !o_id_data[15]) else $error("word 0 bit 15");
    a_valid_rsvd: assert property (
        o_id_index == 8'h35 |-> o_id_data[15:2] == 14'h0000)
        else $error("word 53 reserved bits set");
    a_multset_rsvd: assert property (
        o_id_index == 8'h3B |-> o_id_data[15:9] == 7'h00)
        else $error("word 59 reserved bits set");
    a_advpio_rsvd: assert property (
        o_id_index == 8'h40 |-> o_id_data[15:2] == 14'h0000)
        else $error("word 64 reserved bits set");
    a_capab_rsvd: assert property (
        o_id_index == 8'h31 |-> o_id_data[15:14] == 2'h0 && !o_id_data[12])
        else $error("word 49 reserved bits set");
    a_rsvd_words: assert property (
        o_id_index inside {8'h02, 8'h30, 8'h32, [8'h45:8'h7F], [8'hA0:8'hFF]}
        |-> o_id_data == 16'h0000) else $error("reserved word not zero");
endmodule : ipb_block_monitor

bind ipb_block ipb_block_monitor #(.NUM_WORDS(NUM_WORDS)) u_mon (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_id_start(i_id_start), .o_id_data(o_id_data),
    .o_id_index(o_id_index));

// ---- ipb_host_model.sv ----
// Host reader model: walks all 256 words over the sequential port.
// Assumes the block updates index and data at the edge of each pulse.
`timescale 1ns/1ps
module ipb_host_model (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [3:0] i_gap,
    input wire logic [15:0] i_id_data,
    output logic o_id_start,
    output logic o_id_next,
    output logic o_busy,
    output logic [15:0] o_long_len
);
    logic [15:0] img [256];

    // Long transfer length the host would switch to
    assign o_long_len = 16'h0200 + img[22];

    initial begin
        o_id_start = 1'b0;
        o_id_next = 1'b0;
        o_busy = 1'b0;
        forever begin
            @(posedge i_clk);
            if (i_go) begin
                o_busy <= 1'b1;
                o_id_start <= 1'b1;
                for (int k = 0; k < 256; k++) begin
                    @(posedge i_clk);
                    o_id_start <= 1'b0;
                    o_id_next <= 1'b0;
                    @(negedge i_clk);
                    img[k] = i_id_data;
                    @(posedge i_clk);
                    // Gap lets the bench play a slow host
                    repeat (i_gap) @(posedge i_clk);
                    if (k < 255) o_id_next <= 1'b1;
                end
                o_busy <= 1'b0;
            end
        end
    end
endmodule : ipb_host_model

// ---- tb_top.sv ----
// Self-checking bench for the identify parameter block.
// Drives AXI4-Lite directly; the host model reads the word port.
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, go, busy;
    logic awready, wready, bvalid, arready, rvalid, id_start, id_next;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0] wstrb, gap;
    logic [1:0] bresp, rresp, gr;
    logic [7:0] id_index;
    logic [15:0] id_data, long_len;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    // Word index, value written, value expected back
    logic [39:0] rows [30] = '{
        40'h00_FFFF_7FFF, 40'h01_1234_1234,
        40'h03_0010_0010, 40'h06_003F_003F,
        40'h02_FFFF_0000, 40'h0A_4142_4142,
        40'h17_3120_3120, 40'h1B_2020_2020,
        40'h16_0010_0010, 40'h2F_0010_0010,
        40'h3B_FFFF_01FF, 40'h31_FFFF_2FFF,
        40'h3C_5678_5678, 40'h3D_0001_0001,
        40'h3E_0407_0407, 40'h3F_0101_0101,
        40'h41_0078_0078, 40'h44_00B4_00B4,
        40'h40_FFFF_0003, 40'h35_FFFF_0003,
        40'h36_0002_0002, 40'h37_0003_0003,
        40'h38_0004_0004, 40'h39_FFFF_0018,
        40'h3A_FFFF_0000, 40'h45_FFFF_0000,
        40'h64_FFFF_0000, 40'h80_ABCD_ABCD,
        40'hC8_FFFF_0000, 40'h30_FFFF_0000};

    ipb_block u_dut (
        .i_clk(clk), .i_reset_n(rst_n), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .i_id_start(id_start), .i_id_next(id_next),
        .o_id_data(id_data), .o_id_index(id_index));
    ipb_host_model u_host (
        .i_clk(clk), .i_go(go), .i_gap(gap), .i_id_data(id_data),
        .o_id_start(id_start), .o_id_next(id_next), .o_busy(busy),
        .o_long_len(long_len));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [11:0] wa(input logic [7:0] w);
        return {2'b00, w, 2'b00};
    endfunction : wa

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] a);
        tests_run++;
        if (a !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, a);
        end
    endtask : check

    task automatic test_done;
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // Ready rises only once valid is seen, so each answer stands a cycle
    task automatic wr(input logic [11:0] a, input logic [15:0] v,
                      input logic [1:0] er);
        logic hb;
        logic [1:0] br;
        awaddr <= a;
        wdata <= {16'h0000, v};
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        hb = 1'b0;
        br = 2'b00;
        while (!hb) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                hb = 1'b1;
                br = bresp;
            end else if (bvalid) begin
                bready <= 1'b1;
            end
        end
        bready <= 1'b0;
        check("write response", {30'h0, er}, {30'h0, br});
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic hr;
        araddr <= a;
        arvalid <= 1'b1;
        hr = 1'b0;
        d = 32'h0000_0000;
        r = 2'b00;
        while (!hr) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                hr = 1'b1;
                d = rdata;
                r = rresp;
            end else if (rvalid) begin
                rready <= 1'b1;
            end
        end
        rready <= 1'b0;
    endtask : rd

    task automatic rd_chk(input logic [7:0] w, input logic [15:0] e);
        rd(wa(w), got, gr);
        check("read word", {16'h0000, e}, got);
        check("read response", {30'h0, ipb_pkg::RESP_OKAY}, {30'h0, gr});
    endtask : rd_chk

    task automatic host_run(input logic [3:0] g);
        gap <= g;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        while (busy) @(negedge clk);
        @(posedge clk);
        for (int i = 0; i < 30; i++) begin
            check("port word", {16'h0000, rows[i][15:0]},
                  {16'h0000, u_host.img[rows[i][39:32]]});
        end
        check("long length", 32'h0000_0210, {16'h0000, long_len});
        check("port index", 32'h0000_00FF, {24'h00_0000, id_index});
    endtask : host_run

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            test_done();
        end
    end

    initial begin
        rst_n = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        go = 1'b0;
        gap = 4'h0;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(8'h16, 16'h0004);
        rd(ipb_pkg::A_CTRL, got, gr);
        check("control", 32'h0000_0001, got);
        for (int i = 0; i < 30; i++) begin
            wr(wa(rows[i][39:32]), rows[i][31:16], 2'b00);
        end
        for (int i = 0; i < 30; i++) rd_chk(rows[i][39:32], rows[i][15:0]);
        host_run(4'h0);
        host_run(4'h3);
        wr(wa(8'h2F), 16'h0000, 2'b00);
        rd_chk(8'h3B, 16'h0000);
        wr(wa(8'h35), 16'h0001, 2'b00);
        wr(wa(8'h40), 16'h0000, 2'b00);
        wr(wa(8'h3F), 16'h0002, 2'b00);
        rd_chk(8'h35, 16'h0003);
        wr(wa(8'h3F), 16'h0001, 2'b00);
        rd_chk(8'h35, 16'h0001);
        wr(wa(8'h31), 16'h0000, 2'b00);
        rd_chk(8'h31, 16'h0000);
        rd_chk(8'h3C, 16'h0000);
        wr(wa(8'h40), 16'h0001, 2'b00);
        rd_chk(8'h31, 16'h0800);
        wr(wa(8'h37), 16'h00FF, 2'b00);
        wr(wa(8'h38), 16'h00FF, 2'b00);
        wr(wa(8'h36), 16'hFFFF, 2'b00);
        rd_chk(8'h39, 16'h01FF);
        rd_chk(8'h3A, 16'hFE00);
        wr(12'h408, 16'hFFFF, ipb_pkg::RESP_SLVERR);
        rd(12'h408, got, gr);
        check("bad read response", {30'h0, ipb_pkg::RESP_SLVERR}, {30'h0, gr});
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(8'h16, 16'h0004);
        rd_chk(8'h00, 16'h0000);
        test_done();
    end
endmodule : tb_top
